//--- src/ssp_params.svh
// Constants for the set-up switch policy block
// Overview of operation
// - Echo switch at 0 returns every received serial character.
// - Echo switch at 1 returns no received characters.
// - Pause-clear at 1 outside input mode three: grounded trigger acts as a continue command.
// - Setting one trigger-role switch clears the other two, registration and resume.
// - Stop-line at 1 in input modes one and two: trigger acts as stop.
// - Input mode three: trigger is always a stop input.
// - Stop input grounded: abort sequence, decelerate move with last acceleration.
// - Strobe at 1 in input modes one and two: run selected sequence after trigger held scan time, released.
// - Limit-buffer at 0: limit hit discards all pending buffered commands.
// - Limit-buffer at 1: abort limited move, keep buffer, continue.
// - Stop-buffer at 0: serial or input stop clears the command buffer.
// - Stop-buffer at 1: stop halts current move only, buffer continues.
// - Scan time 1 to 200 ms, default 12, debounces sequence inputs.
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
// ==========================================
// Switch command codes
`define SSP_CMD_W 4
`define SSP_CMD_ECHO 4'h0
`define SSP_CMD_PAUSE_CLR 4'h1
`define SSP_CMD_STOP_LINE 4'h2
`define SSP_CMD_STROBE 4'h3
`define SSP_CMD_LIMIT_BUF 4'h4
`define SSP_CMD_STOP_BUF 4'h5
`define SSP_CMD_REGISTRATION 4'h6
`define SSP_CMD_RESUME 4'h7
`define SSP_CMD_SCAN 4'h8
`define SSP_CMD_MODE 4'h9
// ==========================================
// Register offsets (byte addresses)
`define SSP_REG_SWITCHES 4'h0
`define SSP_REG_SCAN 4'h4
`define SSP_REG_MODE 4'h8
`define SSP_REG_STATUS 4'hc
// Switch bit positions
`define SSP_BIT_ECHO 0
`define SSP_BIT_PAUSE_CLR 1
`define SSP_BIT_STOP_LINE 2
`define SSP_BIT_STROBE 3
`define SSP_BIT_LIMIT_BUF 4
`define SSP_BIT_STOP_BUF 5
`define SSP_BIT_REGISTRATION 6
`define SSP_BIT_RESUME 7
// ==========================================
// Reset values and timing
`define SSP_SW_RESET 8'h00
`define SSP_SCAN_MIN_MS 8'h01
`define SSP_SCAN_MAX_MS 8'hc8
`define SSP_SCAN_DEF_MS 8'h0c
`define SSP_MODE_DEF 2'h1
`define SSP_MS_NS 1000000
`define SSP_CLK_NS 4
`define SSP_CYC_PER_MS (`SSP_MS_NS / `SSP_CLK_NS)
`endif

//--- src/ssp_pkg.sv
// Types for the set-up switch policy block
package ssp_pkg;
	typedef enum logic [1:0] {
		SSP_TRIG_IDLE,
		SSP_TRIG_LOW,
		SSP_TRIG_HELD
	} ssp_trig_e;
	typedef logic [7:0] ssp_byte_t;
endpackage

//--- src/ssp_msec_tick.sv
// Millisecond tick generator
`timescale 1ns/100ps
`include "ssp_params.svh"
module ssp_msec_tick #(
	parameter int CYC_PER_MS = `SSP_CYC_PER_MS
) (
	// Clock and control
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic restart,
	// Tick out
	output logic tick
);
	logic [17:0] cnt_q;

	always_ff @(posedge clk) begin
		if (reset || (ce && restart)) begin
			cnt_q <= 18'h0;
			tick <= 1'b0;
		end else if (ce) begin
			if (cnt_q == 18'(CYC_PER_MS - 1)) begin
				cnt_q <= 18'h0;
				tick <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 18'h1;
				tick <= 1'b0;
			end
		end
	end
endmodule

//--- src/ssp_switch_policy.sv
// Set-up switch policy: echo, trigger role, buffer handling on limit and stop
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/100ps
`include "ssp_params.svh"
module ssp_switch_policy #(
	parameter int CYC_PER_MS = `SSP_CYC_PER_MS
) (
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic RESET,
	input wire logic CE,
	// Received serial characters
	input wire ssp_pkg::ssp_byte_t RX_DATA,
	input wire logic RX_VALID,
	// Echo transmit
	output ssp_pkg::ssp_byte_t TX_DATA,
	output logic TX_VALID,
	// Set-up commands from the command buffer, in buffer order
	input wire logic CMD_VALID,
	input wire logic [`SSP_CMD_W-1:0] CMD_CODE,
	input wire ssp_pkg::ssp_byte_t CMD_ARG,
	// Events from the motion logic
	input wire logic SERIAL_STOP,
	input wire logic LIMIT_HIT,
	// Pins, first trigger input active low
	input wire logic FIRST_TRIGGER_INPUT_N,
	input wire logic [3:0] SEQ_SEL,
	// Actions
	output logic CONTINUE_PULSE,
	output logic STOP_PULSE,
	output logic ABORT_SEQ,
	output logic DECEL_STOP,
	output logic ABORT_MOVE,
	output logic FLUSH_BUFFER,
	output logic RUN_SEQ,
	output logic [3:0] RUN_SEQ_NUM,
	// Register port
	input wire logic [3:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA
);
	import ssp_pkg::*;

	logic [7:0] sw_q;
	logic [7:0] scan_q;
	logic [1:0] mode_q;
	logic [1:0] trig_sync_q;
	logic [3:0] sel_s1_q;
	logic [3:0] sel_s2_q;
	logic [3:0] sel_last_q;
	logic [3:0] sel_stable_q;
	logic [7:0] sel_ms_q;
	logic [7:0] hold_ms_q;
	ssp_trig_e trig_q;
	logic trig_low;
	logic trig_fall;
	logic trig_prev_q;
	logic stop_in;
	logic strobe_role;
	logic stop_event;
	logic ms_tick;
	logic sel_restart;
	logic [7:0] wsw;
	logic [7:0] sw_next;
	logic [7:0] scan_next;
	logic [1:0] mode_next;
	logic sw_load;
	logic [7:0] wr_arg;
	logic [3:0] wr_code;

	// ==========================================
	// Pin synchronisers
	always_ff @(posedge CLK) begin
		if (RESET) begin
			trig_sync_q <= 2'h3;
			sel_s1_q <= 4'h0;
			sel_s2_q <= 4'h0;
		end else if (CE) begin
			trig_sync_q <= {trig_sync_q[0], FIRST_TRIGGER_INPUT_N};
			sel_s1_q <= SEQ_SEL;
			sel_s2_q <= sel_s1_q;
		end
	end

	assign trig_low = ~trig_sync_q[1];

	always_ff @(posedge CLK) begin
		if (RESET) begin
			trig_prev_q <= 1'b0;
		end else if (CE) begin
			trig_prev_q <= trig_low;
		end
	end

	assign trig_fall = trig_low & ~trig_prev_q;

	// ==========================================
	// Switch updates from buffer commands or register writes
	always_comb begin
		wr_code = CMD_CODE;
		wr_arg = CMD_ARG;
		sw_load = 1'b0;
		wsw = sw_q;
		sw_next = sw_q;
		scan_next = scan_q;
		mode_next = mode_q;
		if (CMD_VALID) begin
			case (wr_code)
			`SSP_CMD_ECHO: wsw[`SSP_BIT_ECHO] = wr_arg[0];
			`SSP_CMD_PAUSE_CLR: wsw[`SSP_BIT_PAUSE_CLR] = wr_arg[0];
			`SSP_CMD_STOP_LINE: wsw[`SSP_BIT_STOP_LINE] = wr_arg[0];
			`SSP_CMD_STROBE: wsw[`SSP_BIT_STROBE] = wr_arg[0];
			`SSP_CMD_LIMIT_BUF: wsw[`SSP_BIT_LIMIT_BUF] = wr_arg[0];
			`SSP_CMD_STOP_BUF: wsw[`SSP_BIT_STOP_BUF] = wr_arg[0];
			`SSP_CMD_REGISTRATION: wsw[`SSP_BIT_REGISTRATION] = wr_arg[0];
			`SSP_CMD_RESUME: wsw[`SSP_BIT_RESUME] = wr_arg[0];
			`SSP_CMD_SCAN: scan_next = wr_arg;
			`SSP_CMD_MODE: mode_next = wr_arg[1:0];
			default: wsw = sw_q;
			endcase
			sw_load = 1'b1;
		end else if (REG_WR && REG_ADDR == `SSP_REG_SWITCHES) begin
			wsw = REG_WDATA[7:0];
			sw_load = 1'b1;
		end else if (REG_WR && REG_ADDR == `SSP_REG_SCAN) begin
			scan_next = REG_WDATA[7:0];
		end else if (REG_WR && REG_ADDR == `SSP_REG_MODE) begin
			mode_next = REG_WDATA[1:0];
		end
		if (sw_load) begin
			sw_next = wsw;
			// A newly set trigger role wins; the others clear
			if (wsw[`SSP_BIT_PAUSE_CLR] && !sw_q[`SSP_BIT_PAUSE_CLR]) begin
				sw_next[`SSP_BIT_STOP_LINE] = 1'b0;
				sw_next[`SSP_BIT_STROBE] = 1'b0;
				sw_next[`SSP_BIT_REGISTRATION] = 1'b0;
				sw_next[`SSP_BIT_RESUME] = 1'b0;
			end else if (wsw[`SSP_BIT_STOP_LINE] && !sw_q[`SSP_BIT_STOP_LINE]) begin
				sw_next[`SSP_BIT_PAUSE_CLR] = 1'b0;
				sw_next[`SSP_BIT_STROBE] = 1'b0;
				sw_next[`SSP_BIT_REGISTRATION] = 1'b0;
				sw_next[`SSP_BIT_RESUME] = 1'b0;
			end else if (wsw[`SSP_BIT_STROBE] && !sw_q[`SSP_BIT_STROBE]) begin
				sw_next[`SSP_BIT_PAUSE_CLR] = 1'b0;
				sw_next[`SSP_BIT_STOP_LINE] = 1'b0;
				sw_next[`SSP_BIT_REGISTRATION] = 1'b0;
				sw_next[`SSP_BIT_RESUME] = 1'b0;
			end else if (wsw[`SSP_BIT_PAUSE_CLR] || wsw[`SSP_BIT_STOP_LINE]
					|| wsw[`SSP_BIT_STROBE]) begin
				sw_next[`SSP_BIT_REGISTRATION] = 1'b0;
				sw_next[`SSP_BIT_RESUME] = 1'b0;
			end
		end
		// Out-of-range scan times are ignored
		if (scan_next < `SSP_SCAN_MIN_MS || scan_next > `SSP_SCAN_MAX_MS) begin
			scan_next = scan_q;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			sw_q <= `SSP_SW_RESET;
			scan_q <= `SSP_SCAN_DEF_MS;
			mode_q <= `SSP_MODE_DEF;
		end else if (CE) begin
			sw_q <= sw_next;
			scan_q <= scan_next;
			mode_q <= mode_next;
		end
	end

	// ==========================================
	// Echo
	always_ff @(posedge CLK) begin
		if (RESET) begin
			TX_DATA <= 8'h00;
			TX_VALID <= 1'b0;
		end else if (CE) begin
			TX_VALID <= RX_VALID & ~sw_q[`SSP_BIT_ECHO];
			if (RX_VALID) begin
				TX_DATA <= RX_DATA;
			end
		end
	end

	// ==========================================
	// Trigger role decode
	assign stop_in = trig_fall && (mode_q == 2'h3
		|| (sw_q[`SSP_BIT_STOP_LINE] && (mode_q == 2'h1 || mode_q == 2'h2)));
	assign strobe_role = sw_q[`SSP_BIT_STROBE] && mode_q != 2'h3
		&& (mode_q == 2'h1 || mode_q == 2'h2);
	assign stop_event = stop_in | SERIAL_STOP;

	// Millisecond time base, restarted on select change
	assign sel_restart = sel_s2_q != sel_last_q;

	ssp_msec_tick #(
		.CYC_PER_MS(CYC_PER_MS)
	) u_tick (
		.clk(CLK),
		.reset(RESET),
		.ce(CE),
		.restart(sel_restart),
		.tick(ms_tick)
	);

	// Select-input debounce
	always_ff @(posedge CLK) begin
		if (RESET) begin
			sel_last_q <= 4'h0;
			sel_stable_q <= 4'h0;
			sel_ms_q <= 8'h00;
		end else if (CE) begin
			sel_last_q <= sel_s2_q;
			if (sel_restart) begin
				sel_ms_q <= 8'h00;
			end else if (ms_tick && sel_ms_q < scan_q) begin
				sel_ms_q <= sel_ms_q + 8'h01;
			end else if (sel_ms_q >= scan_q) begin
				sel_stable_q <= sel_last_q;
			end
		end
	end

	// Strobe: hold low for scan time then release
	always_ff @(posedge CLK) begin
		if (RESET) begin
			trig_q <= SSP_TRIG_IDLE;
			hold_ms_q <= 8'h00;
		end else if (CE) begin
			case (trig_q)
			SSP_TRIG_IDLE: begin
				hold_ms_q <= 8'h00;
				if (strobe_role && trig_low) begin
					trig_q <= SSP_TRIG_LOW;
				end
			end
			SSP_TRIG_LOW: begin
				if (!trig_low) begin
					trig_q <= SSP_TRIG_IDLE;
				end else if (ms_tick && hold_ms_q >= scan_q) begin
					// Extra tick: first tick may fall early in the hold
					trig_q <= SSP_TRIG_HELD;
				end else if (ms_tick) begin
					hold_ms_q <= hold_ms_q + 8'h01;
				end
			end
			SSP_TRIG_HELD: begin
				if (!trig_low) begin
					trig_q <= SSP_TRIG_IDLE;
				end
			end
			default: trig_q <= SSP_TRIG_IDLE;
			endcase
		end
	end

	// ==========================================
	// Actions
	always_ff @(posedge CLK) begin
		if (RESET) begin
			CONTINUE_PULSE <= 1'b0;
			STOP_PULSE <= 1'b0;
			ABORT_SEQ <= 1'b0;
			DECEL_STOP <= 1'b0;
			ABORT_MOVE <= 1'b0;
			FLUSH_BUFFER <= 1'b0;
			RUN_SEQ <= 1'b0;
			RUN_SEQ_NUM <= 4'h0;
		end else if (CE) begin
			CONTINUE_PULSE <= trig_fall & sw_q[`SSP_BIT_PAUSE_CLR]
				& (mode_q != 2'h3);
			STOP_PULSE <= stop_event;
			ABORT_SEQ <= stop_in;
			DECEL_STOP <= stop_event;
			ABORT_MOVE <= LIMIT_HIT;
			FLUSH_BUFFER <= (LIMIT_HIT & ~sw_q[`SSP_BIT_LIMIT_BUF])
				| (stop_event & ~sw_q[`SSP_BIT_STOP_BUF]);
			RUN_SEQ <= (trig_q == SSP_TRIG_HELD) && !trig_low;
			if ((trig_q == SSP_TRIG_HELD) && !trig_low) begin
				RUN_SEQ_NUM <= sel_stable_q;
			end
		end
	end

	// ==========================================
	// Register read
	always_ff @(posedge CLK) begin
		if (RESET) begin
			REG_RDATA <= 32'h0;
		end else if (CE) begin
			REG_RDATA <= 32'h0;
			if (REG_RD) begin
				case (REG_ADDR)
				`SSP_REG_SWITCHES: REG_RDATA <= {24'h0, sw_q};
				`SSP_REG_SCAN: REG_RDATA <= {24'h0, scan_q};
				`SSP_REG_MODE: REG_RDATA <= {30'h0, mode_q};
				`SSP_REG_STATUS: REG_RDATA <= {24'h0, sel_stable_q, 1'b0, trig_low,
					trig_q == SSP_TRIG_HELD, trig_q == SSP_TRIG_LOW};
				default: REG_RDATA <= 32'h0;
				endcase
			end
		end
	end
endmodule

//--- bench/ssp_switch_policy_chk.sv
// Port checker of the set-up switch policy block
`timescale 1ns/100ps
`include "ssp_params.svh"
module ssp_switch_policy_chk (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	input wire logic CE,
	// Stimulus seen
	input wire ssp_pkg::ssp_byte_t RX_DATA,
	input wire logic RX_VALID,
	input wire logic CMD_VALID,
	input wire logic [`SSP_CMD_W-1:0] CMD_CODE,
	input wire ssp_pkg::ssp_byte_t CMD_ARG,
	input wire logic SERIAL_STOP,
	input wire logic LIMIT_HIT,
	input wire logic FIRST_TRIGGER_INPUT_N,
	input wire logic [3:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	// Results seen
	input wire ssp_pkg::ssp_byte_t TX_DATA,
	input wire logic TX_VALID,
	input wire logic DECEL_STOP,
	input wire logic ABORT_MOVE,
	input wire logic FLUSH_BUFFER,
	input wire logic RUN_SEQ,
	input wire logic [31:0] REG_RDATA
);
	import ssp_pkg::*;
	logic [2:0] sw_q;
	logic quiet;
	assign quiet = CE && !CMD_VALID && !REG_WR;
	// ==========================================
	// Mirror of echo, limit-buffer and stop-buffer switches
	always_ff @(posedge CLK) begin
		if (RESET)
			sw_q <= 3'h0;
		else if (CE && CMD_VALID) begin
			if (CMD_CODE == `SSP_CMD_ECHO)
				sw_q[0] <= CMD_ARG[0];
			if (CMD_CODE == `SSP_CMD_LIMIT_BUF)
				sw_q[1] <= CMD_ARG[0];
			if (CMD_CODE == `SSP_CMD_STOP_BUF)
				sw_q[2] <= CMD_ARG[0];
		end else if (CE && REG_WR && REG_ADDR == `SSP_REG_SWITCHES)
			sw_q <= {REG_WDATA[5], REG_WDATA[4], REG_WDATA[0]};
	end
	// ==========================================
	// Assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	sequence s_rx_echo;
		RX_VALID && quiet && !sw_q[0];
	endsequence
	sequence s_echo_out;
		TX_VALID && TX_DATA == $past(RX_DATA);
	endsequence
	a_echo_on: assert property (s_rx_echo |=> s_echo_out)
		else $error("echo missing");
	a_echo_off: assert property (RX_VALID && quiet && sw_q[0] |=> !TX_VALID)
		else $error("echo while off");
	a_tx_cause: assert property (TX_VALID |-> $past(RX_VALID))
		else $error("echo without character");
	a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 32'h0)
		else $error("read data without read");
	a_limit_flush: assert property (CE && LIMIT_HIT && !sw_q[1]
		|=> ABORT_MOVE && FLUSH_BUFFER)
		else $error("limit kept buffer");
	a_limit_keep: assert property (CE && LIMIT_HIT && sw_q[1] && !SERIAL_STOP
		|=> ABORT_MOVE && !FLUSH_BUFFER)
		else $error("limit flushed buffer");
	a_stop_flush: assert property (CE && SERIAL_STOP && !sw_q[2]
		|=> DECEL_STOP && FLUSH_BUFFER)
		else $error("stop kept buffer");
	a_stop_keep: assert property (CE && SERIAL_STOP && sw_q[2] && !LIMIT_HIT
		|=> DECEL_STOP && !FLUSH_BUFFER)
		else $error("stop flushed buffer");
	a_run_release: assert property ($rose(RUN_SEQ) |-> $past(FIRST_TRIGGER_INPUT_N) && $past(FIRST_TRIGGER_INPUT_N, 2))
		else $error("run before release");
endmodule
bind ssp_switch_policy ssp_switch_policy_chk u_chk (.CLK(CLK), .RESET(RESET), .CE(CE),
	.RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE),
	.CMD_ARG(CMD_ARG), .SERIAL_STOP(SERIAL_STOP), .LIMIT_HIT(LIMIT_HIT), .FIRST_TRIGGER_INPUT_N(FIRST_TRIGGER_INPUT_N),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .DECEL_STOP(DECEL_STOP), .ABORT_MOVE(ABORT_MOVE),
	.FLUSH_BUFFER(FLUSH_BUFFER), .RUN_SEQ(RUN_SEQ), .REG_RDATA(REG_RDATA));

//--- bench/ssp_host_model.sv
// Host model driving the first trigger input
`timescale 1ns/100ps
module ssp_host_model (
	// Clock and request
	input wire logic clk,
	input wire logic go,
	input wire logic [7:0] hold,
	// Trigger pin, pulled up when released
	output logic trig_n
);
	logic [7:0] cnt_q = 8'h00;
	// Ground the pin for hold cycles, then release
	always @(posedge clk) begin
		if (go)
			cnt_q <= hold;
		else if (cnt_q != 8'h00)
			cnt_q <= cnt_q - 8'h01;
	end
	assign trig_n = (cnt_q == 8'h00);
endmodule

//--- bench/test_ssp_switch_policy.sv
// Testbench of the set-up switch policy block
`timescale 1ns/100ps
`include "ssp_params.svh"
module test_ssp_switch_policy;
	import ssp_pkg::*;
	logic CLK, RESET, CE, RX_VALID, TX_VALID, CMD_VALID, SERIAL_STOP, LIMIT_HIT, FIRST_TRIGGER_INPUT_N;
	logic REG_WR, REG_RD, go;
	ssp_byte_t RX_DATA, TX_DATA, CMD_ARG;
	logic [3:0] CMD_CODE, SEQ_SEL, RUN_SEQ_NUM, REG_ADDR;
	logic [31:0] REG_WDATA, REG_RDATA;
	wire [6:0] act;
	logic [7:0] hold;
	int mismatches = 0;
	int n_tests = 0;
	ssp_switch_policy #(.CYC_PER_MS(4)) dut (.CLK(CLK), .RESET(RESET), .CE(CE),
		.RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
		.CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_ARG(CMD_ARG),
		.SERIAL_STOP(SERIAL_STOP), .LIMIT_HIT(LIMIT_HIT), .FIRST_TRIGGER_INPUT_N(FIRST_TRIGGER_INPUT_N), .SEQ_SEL(SEQ_SEL),
		.CONTINUE_PULSE(act[0]), .STOP_PULSE(act[1]), .ABORT_SEQ(act[2]), .DECEL_STOP(act[3]),
		.ABORT_MOVE(act[4]), .FLUSH_BUFFER(act[5]), .RUN_SEQ(act[6]),
		.RUN_SEQ_NUM(RUN_SEQ_NUM), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
	ssp_host_model host (.clk(CLK), .go(go), .hold(hold), .trig_n(FIRST_TRIGGER_INPUT_N));
	// ==========================================
	// Bus and event drivers
	task chk(input logic [31:0] g, input logic [31:0] w);
		n_tests++;
		if (g !== w) begin
			mismatches++;
			$display("MISMATCH %0t value %h expected %h", $time, g, w);
		end
	endtask
	task watch(input int n, input logic [6:0] w, input logic [6:0] c);
		logic [6:0] seen;
		seen = 7'h00;
		repeat (n) begin
			#1 seen |= act;
			@(posedge CLK);
		end
		n_tests++;
		if ((seen & c) !== (w & c)) begin
			mismatches++;
			$display("MISMATCH %0t actions %h expected %h", $time, seen, w);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge CLK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLK);
		REG_WR <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] w);
		@(posedge CLK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge CLK);
		REG_RD <= 1'b0;
		#1 chk(REG_RDATA, w);
	endtask
	task cmd(input logic [3:0] c, input logic [7:0] v);
		@(posedge CLK);
		CMD_VALID <= 1'b1;
		CMD_CODE <= c;
		CMD_ARG <= v;
		@(posedge CLK);
		CMD_VALID <= 1'b0;
	endtask
	task rx(input ssp_byte_t d, input logic on);
		@(posedge CLK);
		RX_VALID <= 1'b1;
		RX_DATA <= d;
		@(posedge CLK);
		RX_VALID <= 1'b0;
		RX_DATA <= ~d;
		#1 chk(TX_VALID, on);
		if (on)
			chk(TX_DATA, d);
	endtask
	task pulse(input logic l, input logic s);
		@(posedge CLK);
		LIMIT_HIT <= l;
		SERIAL_STOP <= s;
		@(posedge CLK);
		LIMIT_HIT <= 1'b0;
		SERIAL_STOP <= 1'b0;
	endtask
	task trig(input logic [7:0] h, input logic [6:0] w, input logic [6:0] c);
		@(posedge CLK);
		go <= 1'b1;
		hold <= h;
		@(posedge CLK);
		go <= 1'b0;
		watch(h + 14, w, c);
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ==========================================
	// Scenarios
	task t_regs;
		rd(`SSP_REG_SWITCHES, 32'h0);
		rd(`SSP_REG_SCAN, 32'h0c);
		rd(`SSP_REG_MODE, 32'h1);
		wr(`SSP_REG_SCAN, 32'hc8);
		wr(`SSP_REG_SCAN, 32'h0);
		rd(`SSP_REG_SCAN, 32'hc8);
		cmd(`SSP_CMD_SCAN, 8'hc9);
		rd(`SSP_REG_SCAN, 32'hc8);
		cmd(`SSP_CMD_SCAN, 8'h02);
		rd(`SSP_REG_SCAN, 32'h02);
		$display("regs done");
	endtask
	task t_echo;
		rx(8'ha5, 1'b1);
		cmd(`SSP_CMD_ECHO, 8'h01);
		rx(8'h3c, 1'b0);
		wr(`SSP_REG_SWITCHES, 32'h0);
		rx(8'h5a, 1'b1);
		$display("echo done");
	endtask
	task t_roles;
		for (int b = 1; b < 4; b++) begin
			cmd(`SSP_CMD_REGISTRATION, 8'h01);
			cmd(`SSP_CMD_RESUME, 8'h01);
			cmd(4'(b), 8'h01);
			rd(`SSP_REG_SWITCHES, 32'h1 << b);
		end
		wr(`SSP_REG_SWITCHES, 32'h0);
		$display("roles done");
	endtask
	task t_trigger;
		cmd(`SSP_CMD_PAUSE_CLR, 8'h01);
		trig(8'd6, 7'h01, 7'h7f);
		cmd(`SSP_CMD_STOP_LINE, 8'h01);
		trig(8'd6, 7'h2e, 7'h6f);
		wr(`SSP_REG_SWITCHES, 32'h0);
		cmd(`SSP_CMD_MODE, 8'h03);
		trig(8'd6, 7'h2e, 7'h6f);
		cmd(`SSP_CMD_MODE, 8'h01);
		cmd(`SSP_CMD_STROBE, 8'h01);
		trig(8'd3, 7'h00, 7'h40);
		trig(8'd20, 7'h40, 7'h47);
		chk(RUN_SEQ_NUM, 32'h9);
		wr(`SSP_REG_SWITCHES, 32'h0);
		$display("trigger done");
	endtask
	task t_modes;
		wr(`SSP_REG_MODE, 32'h2);
		rd(`SSP_REG_MODE, 32'h2);
		cmd(`SSP_CMD_STOP_LINE, 8'h01);
		trig(8'd6, 7'h2e, 7'h6f);
		cmd(`SSP_CMD_MODE, 8'h00);
		trig(8'd6, 7'h00, 7'h6f);
		rd(`SSP_REG_STATUS, 32'h90);
		wr(`SSP_REG_SWITCHES, 32'h0);
		cmd(`SSP_CMD_MODE, 8'h01);
		// Clock enable low: events are not taken
		@(posedge CLK);
		CE <= 1'b0;
		pulse(1'b1, 1'b1);
		watch(4, 7'h00, 7'h3e);
		CE <= 1'b1;
		$display("modes done");
	endtask
	task t_buffers;
		pulse(1'b1, 1'b0);
		watch(4, 7'h30, 7'h30);
		cmd(`SSP_CMD_LIMIT_BUF, 8'h01);
		pulse(1'b1, 1'b0);
		watch(4, 7'h10, 7'h30);
		pulse(1'b0, 1'b1);
		watch(4, 7'h2a, 7'h2e);
		cmd(`SSP_CMD_STOP_BUF, 8'h01);
		pulse(1'b0, 1'b1);
		watch(4, 7'h0a, 7'h2e);
		$display("buffers done");
	endtask
	// ==========================================
	// Clock, reset, sequence and watchdog
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	initial begin
		{RESET, CE} = 2'b11;
		{RX_VALID, CMD_VALID, SERIAL_STOP, LIMIT_HIT, REG_WR, REG_RD, go} = 7'h0;
		{RX_DATA, CMD_ARG, hold, CMD_CODE, REG_ADDR, REG_WDATA} = '0;
		SEQ_SEL = 4'h9;
		repeat (16) @(posedge CLK);
		RESET <= 1'b0;
		t_regs;
		t_echo;
		t_roles;
		t_trigger;
		t_modes;
		t_buffers;
		conclude;
	end
	initial begin
		#20000;
		mismatches++;
		$display("MISMATCH %0t watchdog expired", $time);
		conclude;
	end
endmodule
